// ==== dv/amp_ctrl_regs_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module amp_ctrl_regs_asserts
	import amp_regs_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic scl_pin,
	input wire logic sda_pin,
	input wire logic sda_out,
	input wire logic sda_oe_n,
	input wire logic pwm_cycle_tick,
	input wire logic pwm_full_duty,
	input wire logic clip_mask,
	input wire alarm_in_s alarms,
	input wire diag_result_s meas,
	input wire logic diag_active,
	input wire logic diag_gain_select,
	input wire logic diag_self_loop,
	input wire logic diag_period_select,
	input wire logic [1:0] diag_drive_level,
	input wire logic tdm_slot_16,
	input wire logic fault_clear,
	input wire logic overheat_shutdown,
	input wire logic warn_pin_n,
	input wire logic fault_pin_n
);
	// ----
	// Port relations
	// ----
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence scl_held;
		scl_pin [*4];
	endsequence
	sequence warn_quiet;
		clip_mask && !alarms.current_limit_event && !alarms.other_warn;
	endsequence
	open_drain_a: assert property (sda_out == 1'b0)
		else $error("data pin driven high");
	hold_high_a: assert property (scl_held |-> !$fell(sda_oe_n))
		else $error("data pin pulled while clock high");
	reset_values_a: assert property ($fell(rst) |-> sda_oe_n && warn_pin_n && fault_pin_n && !diag_active)
		else $error("outputs not at reset values");
	clear_pulse_a: assert property (fault_clear |=> !fault_clear)
		else $error("fault clear longer than one cycle");
	warn_mask_a: assert property (warn_quiet |=> warn_pin_n)
		else $error("masked clip on warning pin");
	fault_mask_a: assert property (clip_mask && !alarms.other_fault && !alarms.overheat_event && !overheat_shutdown
		|=> fault_pin_n)
		else $error("masked clip on fault pin");
	overheat_pin_a: assert property (overheat_shutdown |-> ##[0:1] !fault_pin_n)
		else $error("shutdown not on fault pin");
	other_warn_a: assert property (alarms.other_warn |=> !warn_pin_n)
		else $error("warning not on pin");
	other_fault_a: assert property (alarms.other_fault |=> !fault_pin_n)
		else $error("fault not on pin");
	drive_legal_a: assert property ($rose(diag_active) |-> !diag_drive_level[1])
		else $error("run with reserved drive code");
endmodule : amp_ctrl_regs_asserts
`default_nettype wire

// ==== dv/i2c_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
	input wire logic ref_clk,
	input wire logic sda_line,
	output logic scl_pin,
	output logic sda_drive
);
	// ----
	// Bus controller; the device only answers
	// ----
	initial begin
		scl_pin = 1'b1;
		sda_drive = 1'b1;
	end
	// Eight clocks a phase gives 24 clocks a bit, about 833 kHz
	task automatic st(input logic c, input logic d);
		scl_pin <= c;
		sda_drive <= d;
		repeat (8) @(posedge ref_clk);
	endtask : st
	task automatic start();
		st(1'b0, 1'b1);
		st(1'b1, 1'b1);
		st(1'b1, 1'b0);
		st(1'b0, 1'b0);
	endtask : start
	task automatic stop();
		st(1'b0, 1'b0);
		st(1'b1, 1'b0);
		st(1'b1, 1'b1);
	endtask : stop
	task automatic bit_io(input logic d, output logic q);
		st(1'b0, d);
		st(1'b1, d);
		q = sda_line;
		st(1'b0, d);
	endtask : bit_io
	task automatic byte_io(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
		bit_io(ack_in, ack);
	endtask : byte_io
	// Callers keep the window count nonzero
	task automatic wr(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d, output logic nack);
		logic [7:0] q;
		logic [2:0] k;
		start();
		byte_io({dev, 1'b0}, 1'b1, q, k[0]);
		byte_io(a, 1'b1, q, k[1]);
		byte_io(d, 1'b1, q, k[2]);
		stop();
		nack = |k;
	endtask : wr
	task automatic rd(input logic [6:0] dev, input logic [7:0] a, output logic [7:0] d);
		logic [7:0] q;
		logic k;
		start();
		byte_io({dev, 1'b0}, 1'b1, q, k);
		byte_io(a, 1'b1, q, k);
		start();
		byte_io({dev, 1'b1}, 1'b1, q, k);
		byte_io(8'hff, 1'b1, d, k);
		stop();
	endtask : rd
endmodule : i2c_host_model
`default_nettype wire

// ==== dv/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
	import amp_regs_pkg::*;
	localparam logic [6:0] DEV = 7'h2a;
	localparam logic [7:0] ADDRS [12] = '{8'h15, 8'h16, 8'h17, 8'h1b, 8'h1c, 8'h1d, 8'h1e, 8'h21, 8'h22, 8'h23,
		8'h24, 8'h25};
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic pwm_cycle_tick = 1'b0;
	logic pwm_full_duty = 1'b0;
	logic clip_mask = 1'b0;
	logic [2:0] tick_div = 3'h0;
	logic [7:0] rv;
	logic [39:0] want;
	logic nack;
	alarm_in_s alarms = '0;
	diag_result_s meas = '0;
	int n_mismatch = 0;
	int checks_done = 0;
	int n_tick = 0;
	int n_clear = 0;
	int tick_base = 0;
	wire logic scl_pin, sda_drive, sda_pin, sda_out, sda_oe_n, diag_active, diag_gain_select, diag_self_loop;
	wire logic diag_period_select, tdm_slot_16, fault_clear, overheat_shutdown, warn_pin_n, fault_pin_n;
	wire logic [1:0] diag_drive_level;
	assign sda_pin = (sda_oe_n | sda_out) & sda_drive;
	amp_ctrl_regs #(.TARGET_ADDR(DEV)) u_amp_ctrl_regs (.ref_clk, .rst, .scl_pin, .sda_pin, .sda_out, .sda_oe_n,
		.pwm_cycle_tick, .pwm_full_duty, .clip_mask, .alarms, .meas, .diag_active, .diag_gain_select,
		.diag_self_loop, .diag_period_select, .diag_drive_level, .tdm_slot_16, .fault_clear, .overheat_shutdown,
		.warn_pin_n, .fault_pin_n);
	i2c_host_model u_i2c_host_model (.ref_clk, .sda_line(sda_pin), .scl_pin, .sda_drive);
	initial forever #25 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		tick_div <= (tick_div == 3'h4) ? 3'h0 : tick_div + 3'h1;
		pwm_cycle_tick <= (tick_div == 3'h4);
		if (diag_active === 1'b1 && pwm_cycle_tick) n_tick <= n_tick + 1;
		if (fault_clear === 1'b1) n_clear <= n_clear + 1;
	end
	// ----
	// Tasks
	// ----
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic test_done();
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : test_done
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cyc
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_i2c_host_model.wr(DEV, a, d, nack);
		check("write ack", {7'h00, nack}, 8'h00);
	endtask : wr
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		u_i2c_host_model.rd(DEV, a, rv);
		check($sformatf("reg %h", a), rv, exp);
	endtask : rd_chk
	task automatic wait_diag(input logic lvl);
		for (int i = 0; i < 2000 && diag_active !== lvl; i++) @(posedge ref_clk);
		check("diag_active", diag_active, lvl);
		if (diag_active !== lvl) test_done();
	endtask : wait_diag
	task automatic duty_ticks(input int n);
		@(posedge ref_clk iff pwm_cycle_tick);
		pwm_full_duty <= 1'b1;
		repeat (n) @(posedge ref_clk iff pwm_cycle_tick);
		pwm_full_duty <= 1'b0;
	endtask : duty_ticks
	// ----
	// Sequence
	// ----
	initial begin
		cyc(16);
		rst <= 1'b0;
		cyc(4);
		for (int i = 0; i < 12; i++) rd_chk(ADDRS[i], (i == 8) ? 8'h01 : (i == 9) ? 8'h14 : 8'h00);
		rd_chk(8'h30, 8'h00);
		alarms <= 4'h3;
		cyc(3);
		check("warn pin", warn_pin_n, 8'h00);
		check("fault pin", fault_pin_n, 8'h00);
		alarms <= '0;
		for (int p = 0; p < 2; p++) begin
			want = p ? 40'h5a_a55a_c33c : 40'hff_1234_abcd;
			meas <= want;
			wr(8'h16, p ? 8'h94 : 8'h84);
			check("loop", diag_self_loop, 8'h01);
			check("period", diag_period_select, p[7:0]);
			check("drive", diag_drive_level, DRIVE_19MA);
			tick_base = n_tick;
			wr(8'h15, p ? 8'h08 : 8'h88);
			check("gain", diag_gain_select, p ? 8'h00 : 8'h01);
			wait_diag(1'b1);
			wait_diag(1'b0);
			check("ticks", 8'(n_tick - tick_base), p ? 8'h40 : 8'h20);
			meas <= ~want;
			rd_chk(8'h17, want[39:32]);
			rd_chk(8'h1b, want[31:24]);
			rd_chk(8'h1c, want[23:16]);
			rd_chk(8'h1d, want[15:8]);
			rd_chk(8'h1e, want[7:0]);
		end
		wr(8'h16, 8'h08);
		wr(8'h15, 8'h08);
		check("reserved run", diag_active, 8'h00);
		wr(8'h16, 8'h00);
		check("loop", diag_self_loop, 8'h00);
		wr(8'h15, 8'h08);
		check("drive", diag_drive_level, DRIVE_10MA);
		check("run", diag_active, 8'h01);
		wait_diag(1'b0);
		wr(8'h21, 8'h68);
		check("slot", tdm_slot_16, 8'h01);
		alarms.current_limit_event <= 1'b1;
		cyc(3);
		check("warn pin", warn_pin_n, 8'h01);
		rd_chk(8'h25, 8'h01);
		wr(8'h21, 8'h08);
		check("slot", tdm_slot_16, 8'h00);
		check("warn pin", warn_pin_n, 8'h00);
		alarms <= 4'h4;
		cyc(3);
		rd_chk(8'h25, 8'h00);
		alarms <= '0;
		cyc(4);
		check("shutdown", overheat_shutdown, 8'h00);
		wr(8'h21, 8'h00);
		alarms <= 4'h4;
		cyc(3);
		alarms <= '0;
		cyc(4);
		check("shutdown", overheat_shutdown, 8'h01);
		// Clear, read back, then configure the clip window
		wr(8'h21, 8'h80);
		check("shutdown", overheat_shutdown, 8'h00);
		check("clears", n_clear[7:0], 8'h01);
		rd_chk(8'h21, 8'h00);
		wr(8'h23, 8'h03);
		duty_ticks(2);
		cyc(2);
		rd_chk(8'h24, 8'h00);
		duty_ticks(3);
		cyc(2);
		check("warn pin", warn_pin_n, 8'h00);
		rd_chk(8'h24, 8'h01);
		clip_mask <= 1'b1;
		cyc(3);
		check("warn pin", warn_pin_n, 8'h01);
		clip_mask <= 1'b0;
		wr(8'h22, 8'h05);
		check("fault pin", fault_pin_n, 8'h00);
		check("warn pin", warn_pin_n, 8'h01);
		wr(8'h21, 8'h80);
		rd_chk(8'h24, 8'h00);
		wr(8'h23, 8'hff);
		wr(8'h22, 8'h03);
		pwm_full_duty <= 1'b1;
		cyc(3);
		check("warn pin", warn_pin_n, 8'h00);
		pwm_full_duty <= 1'b0;
		cyc(3);
		check("warn pin", warn_pin_n, 8'h01);
		wr(8'h22, 8'h02);
		pwm_full_duty <= 1'b1;
		cyc(3);
		check("warn pin", warn_pin_n, 8'h01);
		rd_chk(8'h24, 8'h00);
		pwm_full_duty <= 1'b0;
		u_i2c_host_model.wr(DEV ^ 7'h01, 8'h22, 8'h01, nack);
		check("foreign ack", {7'h00, nack}, 8'h01);
		wr(8'h24, 8'hff);
		rd_chk(8'h24, 8'h00);
		rd_chk(8'h22, 8'h02);
		test_done();
	end
endmodule : tb
bind amp_ctrl_regs amp_ctrl_regs_asserts u_amp_ctrl_regs_asserts (.ref_clk, .rst, .scl_pin, .sda_pin, .sda_out,
	.sda_oe_n, .pwm_cycle_tick, .pwm_full_duty, .clip_mask, .alarms, .meas, .diag_active, .diag_gain_select,
	.diag_self_loop, .diag_period_select, .diag_drive_level, .tdm_slot_16, .fault_clear, .overheat_shutdown,
	.warn_pin_n, .fault_pin_n);
`default_nettype wire

// ==== rtl/amp_ctrl_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module amp_ctrl_regs
	import amp_regs_pkg::*;
#(
	parameter logic [6:0] TARGET_ADDR = 7'h2a
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic scl_pin,
	input wire logic sda_pin,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic pwm_cycle_tick,
	input wire logic pwm_full_duty,
	input wire logic clip_mask,
	input wire alarm_in_s alarms,
	input wire diag_result_s meas,
	output logic diag_active,
	output logic diag_gain_select,
	output logic diag_self_loop,
	output logic diag_period_select,
	output logic [1:0] diag_drive_level,
	output logic tdm_slot_16,
	output logic fault_clear,
	output logic overheat_shutdown,
	output logic warn_pin_n,
	output logic fault_pin_n
);
	// ----------------------------------------
	// Pin synchronisers and edge detection
	// ----------------------------------------
	logic [1:0] pins_s;
	logic scl_s;
	logic sda_s;
	logic scl_d_ff;
	logic sda_d_ff;

	pin_sync u_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.pin_in({scl_pin, sda_pin}),
		.pin_out(pins_s)
	);

	assign scl_s = pins_s[1];
	assign sda_s = pins_s[0];

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			scl_d_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end else begin
			scl_d_ff <= scl_s;
			sda_d_ff <= sda_s;
		end
	end

	logic bus_start;
	logic bus_stop;
	logic scl_rise;
	logic scl_fall;

	assign bus_start = scl_s && scl_d_ff && sda_d_ff && !sda_s;
	assign bus_stop = scl_s && scl_d_ff && !sda_d_ff && sda_s;
	assign scl_rise = scl_s && !scl_d_ff;
	assign scl_fall = !scl_s && scl_d_ff;

	// ----------------------------------------
	// Serial target state
	// ----------------------------------------
	i2c_state_e state_ff;
	i2c_state_e nxt_state;
	logic [2:0] bits_ff;
	logic [2:0] nxt_bits;
	logic [7:0] shift_ff;
	logic [7:0] nxt_shift;
	logic [7:0] ptr_ff;
	logic [7:0] nxt_ptr;
	logic rdy_ff;
	logic nxt_rdy;
	logic oe_n_ff;
	logic nxt_oe_n;
	logic [7:0] rd_data;
	logic rx_state;
	logic wr_go;

	assign rx_state = (state_ff == I_ADDR) || (state_ff == I_PTR) || (state_ff == I_WR);
	assign wr_go = (state_ff == I_WR) && scl_fall && rdy_ff;

	always_comb begin
		nxt_state = state_ff;
		nxt_bits = bits_ff;
		nxt_shift = shift_ff;
		nxt_ptr = ptr_ff;
		nxt_rdy = rdy_ff;
		nxt_oe_n = oe_n_ff;
		if (bus_stop) begin
			nxt_state = I_IDLE;
			nxt_oe_n = 1'b1;
		end else if (bus_start) begin
			nxt_state = I_ADDR;
			nxt_bits = 3'h0;
			nxt_rdy = 1'b0;
			nxt_oe_n = 1'b1;
		end else if (rx_state && scl_rise) begin
			nxt_shift = {shift_ff[6:0], sda_s};
			nxt_bits = bits_ff + 3'h1;
			nxt_rdy = (bits_ff == 3'h7);
		end else begin
			case (state_ff)
				I_ADDR: begin
					if (scl_fall && rdy_ff) begin
						nxt_rdy = 1'b0;
						if (shift_ff[7:1] == TARGET_ADDR) begin
							nxt_state = I_ADDR_ACK;
							nxt_oe_n = 1'b0;
						end else begin
							nxt_state = I_IDLE;
						end
					end
				end
				I_ADDR_ACK: begin
					if (scl_fall) begin
						nxt_bits = 3'h0;
						if (shift_ff[0]) begin
							nxt_state = I_RD;
							nxt_shift = rd_data;
							nxt_oe_n = rd_data[7];
						end else begin
							nxt_state = I_PTR;
							nxt_oe_n = 1'b1;
						end
					end
				end
				I_PTR: begin
					if (scl_fall && rdy_ff) begin
						nxt_rdy = 1'b0;
						nxt_ptr = shift_ff;
						nxt_state = I_PTR_ACK;
						nxt_oe_n = 1'b0;
					end
				end
				I_PTR_ACK, I_WR_ACK: begin
					if (scl_fall) begin
						nxt_state = I_WR;
						nxt_oe_n = 1'b1;
						nxt_bits = 3'h0;
					end
				end
				I_WR: begin
					if (wr_go) begin
						nxt_rdy = 1'b0;
						nxt_ptr = ptr_ff + 8'h01;
						nxt_state = I_WR_ACK;
						nxt_oe_n = 1'b0;
					end
				end
				I_RD: begin
					if (scl_rise) begin
						nxt_bits = bits_ff + 3'h1;
						nxt_rdy = (bits_ff == 3'h7);
					end else if (scl_fall && rdy_ff) begin
						nxt_rdy = 1'b0;
						nxt_state = I_RD_ACK;
						nxt_oe_n = 1'b1;
					end else if (scl_fall) begin
						nxt_shift = {shift_ff[6:0], 1'b0};
						nxt_oe_n = shift_ff[6];
					end
				end
				I_RD_ACK: begin
					if (scl_rise) begin
						if (sda_s) begin
							nxt_state = I_IDLE;
						end else begin
							nxt_ptr = ptr_ff + 8'h01;
							nxt_rdy = 1'b1;
						end
					end else if (scl_fall && rdy_ff) begin
						nxt_rdy = 1'b0;
						nxt_state = I_RD;
						nxt_bits = 3'h0;
						nxt_shift = rd_data;
						nxt_oe_n = rd_data[7];
					end
				end
				default: begin
					nxt_state = I_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_ff <= I_IDLE;
			bits_ff <= 3'h0;
			shift_ff <= 8'h00;
			ptr_ff <= 8'h00;
			rdy_ff <= 1'b0;
			oe_n_ff <= 1'b1;
		end else begin
			state_ff <= nxt_state;
			bits_ff <= nxt_bits;
			shift_ff <= nxt_shift;
			ptr_ff <= nxt_ptr;
			rdy_ff <= nxt_rdy;
			oe_n_ff <= nxt_oe_n;
		end
	end

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	logic [7:0] ctrl_a_ff;
	logic [7:0] ctrl_b_ff;
	logic [7:0] misc_c_ff;
	logic [7:0] clip_ctrl_ff;
	logic [7:0] clip_window_ff;
	diag_result_s result_ff;
	logic ilim_ff;
	logic clip_seen;
	logic wr_a;
	logic wr_b;
	logic wr_c;
	logic wr_clip;
	logic wr_win;

	assign wr_a = wr_go && (ptr_ff == ADDR_DIAG_CTRL_A);
	assign wr_b = wr_go && (ptr_ff == ADDR_DIAG_CTRL_B);
	assign wr_c = wr_go && (ptr_ff == ADDR_MISC_CTRL_C);
	assign wr_clip = wr_go && (ptr_ff == ADDR_CLIP_CTRL);
	assign wr_win = wr_go && (ptr_ff == ADDR_CLIP_WINDOW);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ctrl_a_ff <= RST_DIAG_CTRL_A;
			ctrl_b_ff <= RST_DIAG_CTRL_B;
			clip_ctrl_ff <= RST_CLIP_CTRL;
			clip_window_ff <= RST_CLIP_WINDOW;
		end else begin
			if (wr_a) ctrl_a_ff <= shift_ff;
			if (wr_b) ctrl_b_ff <= shift_ff;
			if (wr_clip) clip_ctrl_ff <= shift_ff;
			if (wr_win) clip_window_ff <= shift_ff;
		end
	end

	// Clear-fault bit drops on its own one cycle after the write
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			misc_c_ff <= RST_MISC_CTRL_C;
		end else if (wr_c) begin
			misc_c_ff <= shift_ff;
		end else begin
			misc_c_ff[CLEAR_FAULT_BIT] <= 1'b0;
		end
	end

	// Read selection; unmapped offsets read zero
	assign rd_data =
		(ptr_ff == ADDR_DIAG_CTRL_A) ? ctrl_a_ff :
		(ptr_ff == ADDR_DIAG_CTRL_B) ? ctrl_b_ff :
		(ptr_ff == ADDR_IMPEDANCE) ? result_ff.ohms :
		(ptr_ff == ADDR_PHASE_UPPER) ? result_ff.phase[15:8] :
		(ptr_ff == ADDR_PHASE_LOWER) ? result_ff.phase[7:0] :
		(ptr_ff == ADDR_STI_UPPER) ? result_ff.sti[15:8] :
		(ptr_ff == ADDR_STI_LOWER) ? result_ff.sti[7:0] :
		(ptr_ff == ADDR_MISC_CTRL_C) ? misc_c_ff :
		(ptr_ff == ADDR_CLIP_CTRL) ? clip_ctrl_ff :
		(ptr_ff == ADDR_CLIP_WINDOW) ? clip_window_ff :
		(ptr_ff == ADDR_CLIP_STATUS) ? {7'h00, clip_seen} :
		(ptr_ff == ADDR_ILIM_STATUS) ? {7'h00, ilim_ff} :
		8'h00;

	// ----------------------------------------
	// Load diagnostic sequencer
	// ----------------------------------------
	diag_state_e diag_ff;
	diag_state_e nxt_diag;
	logic [6:0] dcnt_ff;
	logic [6:0] dcnt_inc;
	logic [6:0] period;
	logic drive_ok;
	logic run_en;
	logic start_go;
	logic diag_done;

	assign run_en = ctrl_a_ff[RUN_EN_BIT];
	assign drive_ok = (ctrl_b_ff[DRIVE_MSB:DRIVE_LSB] == DRIVE_10MA) ||
		(ctrl_b_ff[DRIVE_MSB:DRIVE_LSB] == DRIVE_19MA);
	assign period = ctrl_b_ff[PERIOD_BIT] ? DIAG_CYCLES_LONG : DIAG_CYCLES_SHORT;
	assign start_go = wr_a && shift_ff[RUN_EN_BIT] && drive_ok;
	assign dcnt_inc = dcnt_ff + 7'h01;
	assign diag_done = (diag_ff == D_RUN) && run_en && pwm_cycle_tick && (dcnt_inc == period);

	always_comb begin
		nxt_diag = diag_ff;
		case (diag_ff)
			D_IDLE: begin
				if (start_go) nxt_diag = D_RUN;
			end
			D_RUN: begin
				if (!run_en || diag_done) nxt_diag = D_IDLE;
			end
			default: begin
				nxt_diag = D_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			diag_ff <= D_IDLE;
			dcnt_ff <= 7'h00;
			result_ff <= '0;
		end else begin
			diag_ff <= nxt_diag;
			if (diag_ff != D_RUN) dcnt_ff <= 7'h00;
			else if (pwm_cycle_tick) dcnt_ff <= dcnt_inc;
			if (diag_done) result_ff <= meas;
		end
	end

	// ----------------------------------------
	// Clip detection and alarm pins
	// ----------------------------------------
	logic clear_req;
	logic clip_show;
	logic nxt_warn;
	logic nxt_fault;
	logic nxt_ohs;
	logic ohs_ff;
	logic fclr_ff;
	logic warn_n_ff;
	logic fault_n_ff;
	logic active_ff;

	assign clear_req = misc_c_ff[CLEAR_FAULT_BIT];

	clip_window_det u_clip (
		.ref_clk(ref_clk),
		.rst(rst),
		.pwm_cycle_tick(pwm_cycle_tick),
		.pwm_full_duty(pwm_full_duty),
		.clip_monitor_on(clip_ctrl_ff[CLIP_EN_BIT]),
		.non_latching(clip_ctrl_ff[CLIP_NOLATCH_BIT]),
		.window(clip_window_ff),
		.clear(clear_req),
		.clip_seen_flag(clip_seen)
	);

	assign clip_show = clip_seen && !clip_mask;
	assign nxt_warn = alarms.other_warn ||
		(alarms.current_limit_event && !misc_c_ff[ILIM_HIDE_BIT]) ||
		(clip_show && !clip_ctrl_ff[CLIP_PIN_BIT]);
	assign nxt_fault = alarms.other_fault || ohs_ff ||
		(clip_show && clip_ctrl_ff[CLIP_PIN_BIT]);
	// Latched shutdown holds until cleared; a new event wins over the clear
	assign nxt_ohs = alarms.overheat_event ||
		(!misc_c_ff[AUTO_RESTART_BIT] && ohs_ff && !clear_req);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ohs_ff <= 1'b0;
			ilim_ff <= 1'b0;
			fclr_ff <= 1'b0;
			warn_n_ff <= 1'b1;
			fault_n_ff <= 1'b1;
			active_ff <= 1'b0;
		end else begin
			ohs_ff <= nxt_ohs;
			ilim_ff <= alarms.current_limit_event;
			fclr_ff <= clear_req;
			warn_n_ff <= !nxt_warn;
			fault_n_ff <= !nxt_fault;
			active_ff <= (nxt_diag == D_RUN);
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign sda_out = 1'b0;
	assign sda_oe_n = oe_n_ff;
	assign diag_active = active_ff;
	assign diag_gain_select = ctrl_a_ff[GAIN_BIT];
	assign diag_self_loop = ctrl_b_ff[SELF_LOOP_BIT];
	assign diag_period_select = ctrl_b_ff[PERIOD_BIT];
	assign diag_drive_level = ctrl_b_ff[DRIVE_MSB:DRIVE_LSB];
	assign tdm_slot_16 = misc_c_ff[TDM16_BIT];
	assign fault_clear = fclr_ff;
	assign overheat_shutdown = ohs_ff;
	assign warn_pin_n = warn_n_ff;
	assign fault_pin_n = fault_n_ff;
endmodule : amp_ctrl_regs
`default_nettype wire

// ==== rtl/amp_regs_pkg.sv ====
// Contract
// - Diagnostic runs only while control A bit 3 is set; bit 7 picks gain 1 or 4.
// - Control B bit 7 turns diagnostic loopback on; clear turns it off.
// - Timing bit picks 32 or 64 cycles; current code 00 is 10 mA, 01 is 19 mA.
// - Impedance result is an 8-bit unsigned read-only value, 0.2496 ohm per step.
// - Phase result is 16 bits: upper byte at 0x1B, lower byte at 0x1C.
// - STI result is 16 bits: upper byte at 0x1D, lower byte at 0x1E.
// - Writing 1 to misc control C bit 7 clears recorded faults.
// - Misc control C bit 6 set means 16-bit TDM slots, clear means 24 or 32.
// - Misc control C bit 5 set hides current-limit events from the warning pin.
// - Misc control C bit 3 clear latches overheat shutdown; set recovers automatically.
// - Clip control bit 2 routes clip to warning pin when 0, fault pin when 1.
// - Clip control bit 1 clear latches clip on the pin; set makes it non-latching.
// - Clip control bit 0 enables clip detection and resets to 1.
// - Clip is reported after window-count consecutive full-duty cycles; window resets to 20.
// - In non-latching mode the clip window value is ignored.
// - Clip status bit 0 reads 1 while clip is detected, else 0.
// - Current-limit status bit 0 reads 1 while a current-limit warning exists.
// - Clip mask input suppresses clip reporting on the selected pin.
package amp_regs_pkg;
	localparam logic [7:0] ADDR_DIAG_CTRL_A = 8'h15;
	localparam logic [7:0] ADDR_DIAG_CTRL_B = 8'h16;
	localparam logic [7:0] ADDR_IMPEDANCE = 8'h17;
	localparam logic [7:0] ADDR_PHASE_UPPER = 8'h1b;
	localparam logic [7:0] ADDR_PHASE_LOWER = 8'h1c;
	localparam logic [7:0] ADDR_STI_UPPER = 8'h1d;
	localparam logic [7:0] ADDR_STI_LOWER = 8'h1e;
	localparam logic [7:0] ADDR_MISC_CTRL_C = 8'h21;
	localparam logic [7:0] ADDR_CLIP_CTRL = 8'h22;
	localparam logic [7:0] ADDR_CLIP_WINDOW = 8'h23;
	localparam logic [7:0] ADDR_CLIP_STATUS = 8'h24;
	localparam logic [7:0] ADDR_ILIM_STATUS = 8'h25;

	localparam logic [7:0] RST_DIAG_CTRL_A = 8'h00;
	localparam logic [7:0] RST_DIAG_CTRL_B = 8'h00;
	localparam logic [7:0] RST_MISC_CTRL_C = 8'h00;
	localparam logic [7:0] RST_CLIP_CTRL = 8'h01;
	localparam logic [7:0] RST_CLIP_WINDOW = 8'h14;

	localparam int GAIN_BIT = 7;
	localparam int RUN_EN_BIT = 3;
	localparam int SELF_LOOP_BIT = 7;
	localparam int PERIOD_BIT = 4;
	localparam int DRIVE_MSB = 3;
	localparam int DRIVE_LSB = 2;
	localparam int CLEAR_FAULT_BIT = 7;
	localparam int TDM16_BIT = 6;
	localparam int ILIM_HIDE_BIT = 5;
	localparam int AUTO_RESTART_BIT = 3;
	localparam int CLIP_PIN_BIT = 2;
	localparam int CLIP_NOLATCH_BIT = 1;
	localparam int CLIP_EN_BIT = 0;

	localparam logic [1:0] DRIVE_10MA = 2'h0;
	localparam logic [1:0] DRIVE_19MA = 2'h1;
	localparam logic [6:0] DIAG_CYCLES_SHORT = 7'h20;
	localparam logic [6:0] DIAG_CYCLES_LONG = 7'h40;

	typedef struct packed {
		logic [7:0] ohms;
		logic [15:0] phase;
		logic [15:0] sti;
	} diag_result_s;

	typedef struct packed {
		logic current_limit_event;
		logic overheat_event;
		logic other_warn;
		logic other_fault;
	} alarm_in_s;

	typedef enum logic [3:0] {
		I_IDLE = 4'h0,
		I_ADDR = 4'h1,
		I_ADDR_ACK = 4'h2,
		I_PTR = 4'h3,
		I_PTR_ACK = 4'h4,
		I_WR = 4'h5,
		I_WR_ACK = 4'h6,
		I_RD = 4'h7,
		I_RD_ACK = 4'h8
	} i2c_state_e;

	typedef enum logic {
		D_IDLE = 1'b0,
		D_RUN = 1'b1
	} diag_state_e;
endpackage : amp_regs_pkg

// ==== rtl/clip_window_det.sv ====
`timescale 1ns/1ps
`default_nettype none
module clip_window_det (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic pwm_cycle_tick,
	input wire logic pwm_full_duty,
	input wire logic clip_monitor_on,
	input wire logic non_latching,
	input wire logic [7:0] window,
	input wire logic clear,
	output logic clip_seen_flag
);
	// ----------------------------------------
	// Consecutive full-duty counter
	// ----------------------------------------
	logic [7:0] run_ff;
	logic clip_ff;
	logic [7:0] nxt_run;
	logic hit;
	logic nxt_clip;

	assign nxt_run = !pwm_full_duty ? 8'h00 : (run_ff == 8'hff) ? run_ff : run_ff + 8'h01;
	assign hit = pwm_cycle_tick && pwm_full_duty && (nxt_run >= window);
	// Set wins over clear; non-latching follows full duty directly
	assign nxt_clip = !clip_monitor_on ? 1'b0 :
		non_latching ? pwm_full_duty :
		(hit || (clip_ff && !clear));

	always_ff @(posedge ref_clk) begin
		if (rst || !clip_monitor_on) begin
			run_ff <= 8'h00;
		end else if (pwm_cycle_tick) begin
			run_ff <= nxt_run;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			clip_ff <= 1'b0;
		end else begin
			clip_ff <= nxt_clip;
		end
	end

	assign clip_seen_flag = clip_ff;
endmodule : clip_window_det
`default_nettype wire

// ==== rtl/pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [1:0] pin_in,
	output logic [1:0] pin_out
);
	// ----------------------------------------
	// Two-stage synchroniser per pin
	// ----------------------------------------
	logic [1:0] meta_ff;
	logic [1:0] sync_ff;

	for (genvar i = 0; i < 2; i++) begin : g_bit
		always_ff @(posedge ref_clk) begin
			if (rst) begin
				meta_ff[i] <= 1'b1;
				sync_ff[i] <= 1'b1;
			end else begin
				meta_ff[i] <= pin_in[i];
				sync_ff[i] <= meta_ff[i];
			end
		end
	end

	assign pin_out = sync_ff;
endmodule : pin_sync
`default_nettype wire
